// ### rtl/fb_address_generator.sv
// Framebuffer address generator with APB register file
// Summary of operation
// - Addresses wrap within a 32 MByte space holding any mix of buffers.
// - Base and offsets may sit on any pixel, no alignment imposed.
// - X and Y are 16-bit two's complement signed coordinates.
// - Origin select bit: 0 top left, 1 bottom left.
// - Bottom left: dest = base - (Y/S)*W + X + pixel offset.
// - Source address is the destination plus the copy source offset.
// - Y is divided by a programmable scanline interval for interleaving.
// - Width product is a sum of three selected partial products.
// - Framebuffer width selection is its own, independent of localbuffer.
// - Linear mapping with no power-of-two line padding.
`timescale 1ns/1ps
module fb_address_generator
  import fb_addr_pkg::*;
#(
  parameter int ADDR_W = fb_addr_pkg::ADDR_W
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fb_addr_pkg::APB_AW-1:0] paddr,
  input wire logic [fb_addr_pkg::APB_DW-1:0] pwdata,
  output logic pready,
  output logic [fb_addr_pkg::APB_DW-1:0] prdata,
  output logic pslverr,
  // Pixel coordinates from the rasterizer
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [fb_addr_pkg::COORD_W-1:0] pix_x,
  input wire logic [fb_addr_pkg::COORD_W-1:0] pix_y,
  // Addresses to framebuffer memory
  output logic fb_valid,
  input wire logic fb_ready,
  output logic [ADDR_W-1:0] fb_dest_addr,
  output logic [ADDR_W-1:0] fb_src_addr
);
  logic [CFG_W-1:0] read_cfg_ff;
  logic [ADDR_W-1:0] window_base_address_ff;
  logic [ADDR_W-1:0] buffer_select_offset_ff;
  logic [ADDR_W-1:0] copy_source_displacement_ff;
  logic [SCAN_W-1:0] scan_shift_ff;
  logic [CNT_W-1:0] issue_cnt_ff;
  logic [APB_DW-1:0] prdata_ff;
  logic [APB_DW-1:0] nxt_prdata;
  logic pslverr_ff;
  logic fb_valid_ff;
  logic [ADDR_W-1:0] dest_ff;
  logic [ADDR_W-1:0] src_ff;
  logic [ADDR_W-1:0] nxt_dest;
  logic [ADDR_W-1:0] nxt_src;
  logic origin_select;
  logic [PP_W-1:0] width_term_a;
  logic [PP_W-1:0] width_term_b;
  logic [PP_W-1:0] width_term_c;
  logic [COORD_W-1:0] y_div;
  logic [ADDR_W-1:0] y_width;
  logic [ADDR_W-1:0] y_term;
  logic apb_setup;
  logic apb_wr;
  logic pix_fire;

  // Register index check, used for the slave error
  function automatic logic reg_mapped(input logic [APB_AW-1:0] a);
    reg_mapped = (a == OFS_READ_CFG) || (a == OFS_WIN_BASE) ||
                 (a == OFS_BUF_SEL) || (a == OFS_COPY_SRC) ||
                 (a == OFS_SCAN_INT) || (a == OFS_LAST_DEST) ||
                 (a == OFS_LAST_SRC) || (a == OFS_ISSUE_CNT);
  endfunction

  // Sign extension of a coordinate to address width
  function automatic logic [ADDR_W-1:0] sext(input logic [COORD_W-1:0] v);
    sext = {{(ADDR_W-COORD_W){v[COORD_W-1]}}, v};
  endfunction

  // Zero extension of a field to bus width
  function automatic logic [APB_DW-1:0] zext(input logic [ADDR_W-1:0] v);
    zext = {{(APB_DW-ADDR_W){1'b0}}, v};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // APB access strobes
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  // Read configuration: origin and width selects
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      read_cfg_ff <= RST_CFG;
    else if (apb_wr && paddr == OFS_READ_CFG)
      read_cfg_ff <= pwdata[CFG_W-1:0];
  end

  // Window base, any pixel boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      window_base_address_ff <= RST_ADDR;
    else if (apb_wr && paddr == OFS_WIN_BASE)
      window_base_address_ff <= pwdata[ADDR_W-1:0];
  end

  // Alternative buffer offset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      buffer_select_offset_ff <= RST_ADDR;
    else if (apb_wr && paddr == OFS_BUF_SEL)
      buffer_select_offset_ff <= pwdata[ADDR_W-1:0];
  end

  // Copy source displacement
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      copy_source_displacement_ff <= RST_ADDR;
    else if (apb_wr && paddr == OFS_COPY_SRC)
      copy_source_displacement_ff <= pwdata[ADDR_W-1:0];
  end

  // Scanline interval as a power of two
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      scan_shift_ff <= RST_SCAN;
    else if (apb_wr && paddr == OFS_SCAN_INT)
      scan_shift_ff <= pwdata[SCAN_W-1:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data mux
  always_comb
  begin
    nxt_prdata = '0;
    if (paddr == OFS_READ_CFG)
      nxt_prdata = {{(APB_DW-CFG_W){1'b0}}, read_cfg_ff};
    else if (paddr == OFS_WIN_BASE)
      nxt_prdata = zext(window_base_address_ff);
    else if (paddr == OFS_BUF_SEL)
      nxt_prdata = zext(buffer_select_offset_ff);
    else if (paddr == OFS_COPY_SRC)
      nxt_prdata = zext(copy_source_displacement_ff);
    else if (paddr == OFS_SCAN_INT)
      nxt_prdata = {{(APB_DW-SCAN_W){1'b0}}, scan_shift_ff};
    else if (paddr == OFS_LAST_DEST)
      nxt_prdata = zext(dest_ff);
    else if (paddr == OFS_LAST_SRC)
      nxt_prdata = zext(src_ff);
    else if (paddr == OFS_ISSUE_CNT)
      nxt_prdata = {{(APB_DW-CNT_W){1'b0}}, issue_cnt_ff};
  end

  // Read data and error loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata_ff <= pwrite ? '0 : nxt_prdata;
      pslverr_ff <= ~reg_mapped(paddr);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address arithmetic
  assign origin_select = read_cfg_ff[ORIGIN_POS];
  assign width_term_a = read_cfg_ff[PPA_LSB +: PP_W];
  assign width_term_b = read_cfg_ff[PPB_LSB +: PP_W];
  assign width_term_c = read_cfg_ff[PPC_LSB +: PP_W];

  scanline_scaler u_scaler (
    .y_in(pix_y),
    .interval_log2(scan_shift_ff),
    .y_scaled(y_div)
  );

  width_product #(.ADDR_W(ADDR_W)) u_width (
    .y_scaled(y_div),
    .sel_a(width_term_a),
    .sel_b(width_term_b),
    .sel_c(width_term_c),
    .product(y_width)
  );

  // Bottom left subtracts the Y term, top left adds it
  assign y_term = origin_select ? (ADDR_W'(0) - y_width) : y_width;
  // Linear sum, modulo the address space
  assign nxt_dest = window_base_address_ff + y_term + sext(pix_x) +
                    buffer_select_offset_ff;
  assign nxt_src = nxt_dest + copy_source_displacement_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Output stage
  assign pix_ready = ~fb_valid_ff | fb_ready;
  assign pix_fire = pix_valid & pix_ready;
  assign fb_valid = fb_valid_ff;
  assign fb_dest_addr = dest_ff;
  assign fb_src_addr = src_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fb_valid_ff <= 1'b0;
    else if (pix_ready)
      fb_valid_ff <= pix_valid;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dest_ff <= RST_ADDR;
      src_ff <= RST_ADDR;
    end
    else if (pix_fire)
    begin
      dest_ff <= nxt_dest;
      src_ff <= nxt_src;
    end
  end

  // Count of issued address pairs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      issue_cnt_ff <= RST_CNT;
    else if (pix_fire)
      issue_cnt_ff <= issue_cnt_ff + CNT_W'(1);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [ADDR_W-1:0] chk_w;
  logic [ADDR_W-1:0] chk_y;
  logic [ADDR_W-1:0] chk_dest;

  function automatic logic [ADDR_W-1:0] w_of(input logic [PP_W-1:0] s);
    w_of = (s == '0) ? '0 : (ADDR_W'(1) << (s + PP_BASE_SHIFT));
  endfunction

  always_comb
  begin
    chk_w = w_of(width_term_a) + w_of(width_term_b) + w_of(width_term_c);
    chk_y = sext($signed(pix_y) >>> scan_shift_ff);
    chk_dest = origin_select ?
               window_base_address_ff - chk_y * chk_w :
               window_base_address_ff + chk_y * chk_w;
    chk_dest = chk_dest + sext(pix_x) + buffer_select_offset_ff;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_apb_access;
    psel && penable && pready;
  endsequence

  sequence s_pix_take;
    pix_valid && pix_ready;
  endsequence

  a_bottom_left_math:
    assert property (s_pix_take and origin_select |=> fb_dest_addr == $past(chk_dest))
    else $error("bottom left destination address wrong");

  a_top_left_math:
    assert property (s_pix_take and !origin_select |=> fb_dest_addr == $past(chk_dest))
    else $error("top left destination address wrong");

  a_source_offset:
    assert property (s_pix_take |=> fb_valid &&
      fb_src_addr == fb_dest_addr + $past(copy_source_displacement_ff))
    else $error("source address not destination plus displacement");

  a_signed_x_coord:
    assert property (s_pix_take and pix_y == '0 |=> fb_dest_addr ==
      $past(window_base_address_ff + sext(pix_x) + buffer_select_offset_ff))
    else $error("x coordinate not sign extended");

  a_origin_direction:
    assert property (s_pix_take and pix_y == COORD_W'(1) and scan_shift_ff == '0 |=>
      fb_dest_addr == $past(window_base_address_ff + sext(pix_x) +
      buffer_select_offset_ff + (origin_select ? ADDR_W'(0) - chk_w : chk_w)))
    else $error("origin select steers the y term the wrong way");

  a_scan_interval:
    assert property (s_pix_take and pix_y == (COORD_W'(1) << scan_shift_ff) and
      !pix_y[COORD_W-1] and !origin_select and pix_x == '0 |=> fb_dest_addr ==
      $past(window_base_address_ff + buffer_select_offset_ff + chk_w))
    else $error("scanline interval not applied");

  a_width_terms:
    assert property (y_width == sext(y_div) * chk_w)
    else $error("width partial products wrong");

  a_addr_wrap:
    assert property (s_pix_take and pix_x == '0 and pix_y == '0 |=>
      fb_dest_addr == $past(window_base_address_ff + buffer_select_offset_ff))
    else $error("address does not wrap in the address space");

  a_pixel_align:
    assert property (s_pix_take and pix_y == '0 and pix_x == '0 and
      buffer_select_offset_ff == '0 |=> fb_dest_addr == $past(window_base_address_ff))
    else $error("window base was realigned");

  a_no_padding:
    assert property (s_pix_take and pix_y == COORD_W'(1) and !origin_select and
      scan_shift_ff == '0 and pix_x == '0 |=> fb_dest_addr -
      $past(window_base_address_ff + buffer_select_offset_ff) == $past(chk_w))
    else $error("line stride is not the selected width");

  a_cfg_fields:
    assert property (s_apb_access and pwrite and paddr == OFS_READ_CFG |=>
      {width_term_c, width_term_b, width_term_a} == $past(pwdata[PPA_LSB +: 3*PP_W]))
    else $error("width selects not taken from configuration write");

  a_output_hold:
    assert property (fb_valid && !fb_ready |=> fb_valid && $stable(fb_dest_addr) &&
      $stable(fb_src_addr))
    else $error("address output changed while stalled");

  a_apb_answer:
    assert property (s_apb_setup ##1 penable |-> pready &&
      pslverr == !reg_mapped($past(paddr)))
    else $error("apb answer wrong");

endmodule // fb_address_generator

// ### rtl/fb_addr_pkg.sv
// Constants for the framebuffer address generator
package fb_addr_pkg;
  // Widths
  localparam int ADDR_W = 25;
  localparam int COORD_W = 16;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int PP_W = 3;
  localparam int SCAN_W = 4;
  localparam int CFG_W = 10;
  localparam int CNT_W = 16;
  localparam int NUM_TERMS = 3;
  localparam int PP_BASE_SHIFT = 4;
  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [APB_AW-1:0] OFS_READ_CFG = 8'h00;
  localparam logic [APB_AW-1:0] OFS_WIN_BASE = 8'h04;
  localparam logic [APB_AW-1:0] OFS_BUF_SEL = 8'h08;
  localparam logic [APB_AW-1:0] OFS_COPY_SRC = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_SCAN_INT = 8'h10;
  localparam logic [APB_AW-1:0] OFS_LAST_DEST = 8'h14;
  localparam logic [APB_AW-1:0] OFS_LAST_SRC = 8'h18;
  localparam logic [APB_AW-1:0] OFS_ISSUE_CNT = 8'h1C;
  //////////////////////////////////////////////////////////////////////////////
  // Field positions of pixel_read_config
  localparam int ORIGIN_POS = 0;
  localparam int PPA_LSB = 1;
  localparam int PPB_LSB = 4;
  localparam int PPC_LSB = 7;
  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [CFG_W-1:0] RST_CFG = 10'h000;
  localparam logic [ADDR_W-1:0] RST_ADDR = 25'h0000000;
  localparam logic [SCAN_W-1:0] RST_SCAN = 4'h0;
  localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
endpackage

// ### rtl/scanline_scaler.sv
// Divides a signed Y coordinate by the scanline interval
`timescale 1ns/1ps
module scanline_scaler
  import fb_addr_pkg::*;
(
  // Coordinate in
  input wire logic [fb_addr_pkg::COORD_W-1:0] y_in,
  input wire logic [fb_addr_pkg::SCAN_W-1:0] interval_log2,
  // Scaled coordinate out
  output logic [fb_addr_pkg::COORD_W-1:0] y_scaled
);
  // Arithmetic shift keeps the sign of Y
  assign y_scaled = $signed(y_in) >>> interval_log2;
endmodule // scanline_scaler

// ### rtl/width_product.sv
// Forms Y times width as a sum of selected partial products
`timescale 1ns/1ps
module width_product
  import fb_addr_pkg::*;
#(
  parameter int ADDR_W = fb_addr_pkg::ADDR_W
)
(
  // Scaled Y and width selects
  input wire logic [fb_addr_pkg::COORD_W-1:0] y_scaled,
  input wire logic [fb_addr_pkg::PP_W-1:0] sel_a,
  input wire logic [fb_addr_pkg::PP_W-1:0] sel_b,
  input wire logic [fb_addr_pkg::PP_W-1:0] sel_c,
  // Product
  output logic [ADDR_W-1:0] product
);
  logic [ADDR_W-1:0] y_ext;
  logic [PP_W-1:0] sel [NUM_TERMS];
  logic [ADDR_W-1:0] term [NUM_TERMS];
  // Zero select gives no term, otherwise a shifted copy of Y
  function automatic logic [ADDR_W-1:0] pp_term(input logic [PP_W-1:0] s,
                                                 input logic [ADDR_W-1:0] v);
    pp_term = (s == '0) ? '0 : (v << (s + PP_BASE_SHIFT));
  endfunction
  assign y_ext = {{(ADDR_W-COORD_W){y_scaled[COORD_W-1]}}, y_scaled};
  assign sel[0] = sel_a;
  assign sel[1] = sel_b;
  assign sel[2] = sel_c;
  for (genvar g = 0; g < NUM_TERMS; g++)
  begin : g_term
    assign term[g] = pp_term(sel[g], y_ext);
  end
  assign product = term[0] + term[1] + term[2];
endmodule // width_product

// ### bench/fb_mem_model.sv
// Framebuffer memory side model that accepts address pairs
`timescale 1ns/1ps
module fb_mem_model
  import fb_addr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Address pairs from the generator
  input wire logic fb_valid,
  output logic fb_ready,
  input wire logic [fb_addr_pkg::ADDR_W-1:0] fb_dest_addr,
  input wire logic [fb_addr_pkg::ADDR_W-1:0] fb_src_addr,
  // Pacing control
  input wire logic slow
);
  logic [1:0] pace_ff;
  logic [ADDR_W-1:0] dest_q[$], src_q[$];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pace_ff <= 2'h0;
    else
      pace_ff <= pace_ff + 2'h1;
  end
  // Ready at once, or one cycle in four when slow
  assign fb_ready = !slow || (pace_ff == 2'h3);
  // Records accepted pairs in order
  always @(posedge pclk)
  begin
    if (presetn && fb_valid && fb_ready)
    begin
      dest_q.push_back(fb_dest_addr);
      src_q.push_back(fb_src_addr);
    end
  end
endmodule // fb_mem_model

// ### bench/fb_address_generator_tb.sv
// Testbench for the framebuffer address generator
`timescale 1ns/1ps
module fb_address_generator_tb;
  import fb_addr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pix_valid, slow;
  logic pready, pslverr, pix_ready, fb_valid, fb_ready;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata;
  logic [COORD_W-1:0] pix_x, pix_y, px, py;
  logic [ADDR_W-1:0] fb_dest_addr, fb_src_addr, ed;
  logic [ADDR_W-1:0] exp_d[$], exp_s[$];
  int fail_count, checked;
  //////////////////////////////////////////////////////////////////////////////
  // Configuration table; widths 1280, 1024, 2592, 224 and zero
  logic org_tab [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [PP_W-1:0] a_tab [6] = '{3'h6, 3'h6, 3'h6, 3'h7, 3'h1, 3'h0};
  logic [PP_W-1:0] b_tab [6] = '{3'h4, 3'h4, 3'h0, 3'h5, 3'h2, 3'h0};
  logic [PP_W-1:0] c_tab [6] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h3, 3'h0};
  logic [SCAN_W-1:0] scan_tab [6] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h0};
  logic [ADDR_W-1:0] base_tab [6] = '{25'h0000123, 25'h0140000, 25'h1FFFFF0,
    25'h0000001, 25'h1000003, 25'h0000000};
  logic [ADDR_W-1:0] bsel_tab [6] = '{25'h0, 25'h0, 25'h0100000, 25'h0, 25'h0, 25'h1FFFFFF};
  logic [ADDR_W-1:0] copy_tab [6] = '{25'h0, 25'h0000400, 25'h0, 25'h1FFFF00, 25'h0, 25'h0};
  logic [COORD_W-1:0] xs [4] = '{16'h0000, 16'h0019, 16'hFFFD, 16'h7FFF};
  logic [COORD_W-1:0] ys [4] = '{16'h0000, 16'h0007, 16'hFFF9, 16'h0013};
  //////////////////////////////////////////////////////////////////////////////
  fb_address_generator #(.ADDR_W(ADDR_W)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_x(pix_x), .pix_y(pix_y), .fb_valid(fb_valid), .fb_ready(fb_ready),
    .fb_dest_addr(fb_dest_addr), .fb_src_addr(fb_src_addr));
  fb_mem_model u_fbm (.pclk(pclk), .presetn(presetn), .fb_valid(fb_valid), .fb_ready(fb_ready),
    .fb_dest_addr(fb_dest_addr), .fb_src_addr(fb_src_addr), .slow(slow));
  always #2 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic timeout(string what);
    fail_count++;
    $display("CHECK FAILED t=%0t timeout on %s", $time, what);
    summarize();
  endtask
  task automatic check(logic [31:0] got, logic [31:0] exp, string what);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb_xfer(logic wr, logic [APB_AW-1:0] a, logic [APB_DW-1:0] d,
                          output logic [APB_DW-1:0] q, output logic err);
    int w;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    w = 0;
    while (pready !== 1'b1 && w < 50)
    begin
      @(posedge pclk);
      w++;
    end
    if (w >= 50)
      timeout("apb");
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic apb_write(logic [APB_AW-1:0] a, logic [APB_DW-1:0] d);
    logic [APB_DW-1:0] q;
    logic e;
    apb_xfer(1'b1, a, d, q, e);
  endtask
  task automatic apb_read(logic [APB_AW-1:0] a, logic [APB_DW-1:0] exp, logic experr);
    logic [APB_DW-1:0] q;
    logic e;
    apb_xfer(1'b0, a, 32'h0, q, e);
    check(q, exp, "read data");
    check({31'h0, e}, {31'h0, experr}, "slave error");
  endtask
  // Holds a coordinate until the edge that takes it
  task automatic send_pixel(logic [COORD_W-1:0] x, logic [COORD_W-1:0] y);
    int w;
    pix_valid <= 1'b1;
    pix_x <= x;
    pix_y <= y;
    w = 0;
    @(posedge pclk);
    while (pix_ready !== 1'b1 && w < 50)
    begin
      @(posedge pclk);
      w++;
    end
    if (w >= 50)
      timeout("pixel");
  endtask
  function automatic logic [ADDR_W-1:0] term(logic [PP_W-1:0] s);
    return (s == 3'h0) ? 25'h0 : (25'h1 << (s + 4));
  endfunction
  function automatic logic [ADDR_W-1:0] calc_dest(int k, logic [COORD_W-1:0] x,
                                                  logic [COORD_W-1:0] y);
    logic [ADDR_W-1:0] w, p;
    logic signed [ADDR_W-1:0] yq;
    w = term(a_tab[k]) + term(b_tab[k]) + term(c_tab[k]);
    yq = $signed(y) >>> scan_tab[k];
    p = yq * w;
    if (org_tab[k])
      p = -p;
    return base_tab[k] + p + {{(ADDR_W-COORD_W){x[COORD_W-1]}}, x} + bsel_tab[k];
  endfunction
  task automatic drain();
    int w;
    w = 0;
    while (u_fbm.dest_q.size() < exp_d.size() && w < 400)
    begin
      @(posedge pclk);
      w++;
    end
    if (w >= 400)
      timeout("address pairs");
    while (exp_d.size() > 0)
    begin
      check(32'(u_fbm.dest_q.pop_front()), 32'(exp_d.pop_front()), "dest");
      check(32'(u_fbm.src_q.pop_front()), 32'(exp_s.pop_front()), "source");
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, pix_valid, slow} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pix_x = 16'h0000;
    pix_y = 16'h0000;
    fail_count = 0;
    checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int r = 0; r < 8; r++)
      apb_read(8'(4 * r), 32'h0, 1'b0);
    apb_read(8'h20, 32'h0, 1'b1);
    apb_write(OFS_LAST_DEST, 32'h00005A5A);
    apb_read(OFS_LAST_DEST, 32'h0, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      slow <= k[0];
      apb_write(OFS_READ_CFG, {22'h3FFFFF, c_tab[k], b_tab[k], a_tab[k], org_tab[k]});
      apb_write(OFS_WIN_BASE, {7'h7F, base_tab[k]});
      apb_write(OFS_BUF_SEL, {7'h00, bsel_tab[k]});
      apb_write(OFS_COPY_SRC, {7'h00, copy_tab[k]});
      apb_write(OFS_SCAN_INT, {28'h0, scan_tab[k]});
      apb_read(OFS_READ_CFG, {22'h0, c_tab[k], b_tab[k], a_tab[k], org_tab[k]}, 1'b0);
      apb_read(OFS_WIN_BASE, {7'h00, base_tab[k]}, 1'b0);
      // Fifth pixel sits one scaled line down at column zero
      for (int i = 0; i < 5; i++)
      begin
        px = (i < 4) ? xs[i % 4] : 16'h0000;
        py = (i < 4) ? ys[i % 4] : (COORD_W'(1) << scan_tab[k]);
        ed = calc_dest(k, px, py);
        exp_d.push_back(ed);
        exp_s.push_back(ed + copy_tab[k]);
        send_pixel(px, py);
      end
      pix_valid <= 1'b0;
      drain();
    end
    apb_read(OFS_ISSUE_CNT, 32'h0000001E, 1'b0);
    apb_read(OFS_LAST_DEST, {7'h00, ed}, 1'b0);
    apb_read(OFS_LAST_SRC, {7'h00, ed + copy_tab[5]}, 1'b0);
    summarize();
  end
endmodule // fb_address_generator_tb
